// file: logic/flbc_pkg.sv
// Constants shared by the flash bus-operation control block
package flbc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int CTRL_W = 6;

  // ----------------------------------------------------------------
  // Control pin bundle positions after synchronising
  // ----------------------------------------------------------------
  localparam int POS_CE = 0;
  localparam int POS_OE = 1;
  localparam int POS_WE = 2;
  localparam int POS_ADV = 3;
  localparam int POS_HR = 4;
  localparam int POS_FCLK = 5;
  localparam logic [5:0] CTRL_IDLE = 6'h1F;

  // ----------------------------------------------------------------
  // Command codes and values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_CONFIG = 8'h60;
  localparam logic [7:0] CMD_CONFIG_SET = 8'h03;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam int SYNC_MODE_ADDR_BIT = 0;

  // ----------------------------------------------------------------
  // Timing at 250 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_ABORT_MAX_NS = 25000;
  localparam int RESET_ABORT_CYCLES = RESET_ABORT_MAX_NS / CLK_PERIOD_NS;
  localparam int PROG_TIME_NS = 200000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_TIME_US = 4000000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * (1000 / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RD_ARRAY = 2'b01,
    RD_STATUS = 2'b10
  } flbc_rd_mode_t;

  typedef enum logic [3:0] {
    CMD_ST_IDLE = 4'b0001,
    CMD_ST_PROG = 4'b0010,
    CMD_ST_ERASE = 4'b0100,
    CMD_ST_CONFIG = 4'b1000
  } flbc_cmd_state_t;

  typedef enum logic [2:0] {
    WSM_IDLE = 3'b001,
    WSM_PROG = 3'b010,
    WSM_ERASE = 3'b100
  } flbc_wsm_state_t;

endpackage

// file: logic/flbc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module flbc_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  // Stage one feeds stage two only; the filter sees stages two and three
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          s1_reg <= RESET_VAL[g];
          s2_reg <= RESET_VAL[g];
          s3_reg <= RESET_VAL[g];
          level_out[g] <= RESET_VAL[g];
        end else begin
          s1_reg <= pin_in[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            level_out[g] <= s3_reg;
          end
        end
      end
    end
  endgenerate

endmodule

// file: logic/flbc_bus_ctrl.sv
// Bus-operation control of a 16-bit parallel NOR flash device
// Contract
// R1: Reads are accepted only with chip select low and hard reset high.
// R2: Upper address bits select the target block.
// R3: Async mode: address latch transparent while address valid low, holds on rise.
// R4: Sync mode: address taken on address valid rise or first clock edge.
// R5: Host reads with reset, write enable high, select and output enable low.
// R6: Host writes with select, write enable low, reset, output enable high.
// R7: Write address and data taken on first rise of write enable or select.
// R8: Output enable high floats all data pins and the wait pin.
// R9: Chip select high means standby with data pins floating.
// R10: Deselecting never stops a running program or erase.
// R11: After reset release: async array read, status 0x80.
// R12: Hard reset low aborts work, floats outputs, ignores other controls.
// R13: Reset during program or erase marks target contents invalid.
// R14: Host waits a recovery time after reset before reads or writes.
// R15: Commands go to a command interface with no address of its own.
// R16: Write state machine runs program and erase on its own.
// R17: Host should drive hard reset from the processor reset.
// R18: Host holds hard reset low at least 100 ns; the bench's power-up reset holds it low only 31 ns.
// R19: Reset during program or erase completes within 25 us.
// R20: Command 0xFF returns the device to array read.
// R21: Sync reads with clock running drive the wait pin actively.
`timescale 1ns/10ps
module flbc_bus_ctrl #(
  parameter int ADDR_W = 8,
  parameter int BLK_W = 2,
  parameter int PROG_CYC = flbc_pkg::PROG_CYCLES,
  parameter int ERASE_CYC = flbc_pkg::ERASE_CYCLES,
  parameter int ABORT_MAX_CYC = flbc_pkg::RESET_ABORT_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic flash_clk_in,
  input wire logic hard_reset_n_in,
  input wire logic chip_sel_n_in,
  input wire logic out_en_n_in,
  input wire logic write_en_n_in,
  input wire logic address_valid_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [flbc_pkg::DATA_W-1:0] dq_in,
  output logic [flbc_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  output logic wait_out,
  output logic wait_oe_out,
  output logic wsm_busy_out,
  output logic sync_mode_out,
  output logic [(1<<BLK_W)-1:0] invalid_blocks_out
);
  import flbc_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [CTRL_W-1:0] ctrl_prev_reg;

  flbc_pin_sync #(.WIDTH(CTRL_W), .RESET_VAL(CTRL_IDLE)) u_ctrl_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .pin_in({flash_clk_in, hard_reset_n_in, address_valid_n_in,
             write_en_n_in, out_en_n_in, chip_sel_n_in}),
    .level_out(ctrl_s)
  );
  flbc_pin_sync #(.WIDTH(ADDR_W), .RESET_VAL('0)) u_addr_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .pin_in(addr_in),
    .level_out(addr_s)
  );
  flbc_pin_sync #(.WIDTH(DATA_W), .RESET_VAL('0)) u_data_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .pin_in(dq_in),
    .level_out(data_s)
  );

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_prev_reg <= CTRL_IDLE;
    end else begin
      ctrl_prev_reg <= ctrl_s;
    end
  end

  // ----------------------------------------------------------------
  // Decoded bus states
  // ----------------------------------------------------------------
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic adv_n;
  logic hr_n;
  logic adv_rise;
  logic fclk_rise;
  logic rd_sel;
  logic reading;
  logic wr_active;
  logic wr_end;

  assign ce_n = ctrl_s[POS_CE];
  assign oe_n = ctrl_s[POS_OE];
  assign we_n = ctrl_s[POS_WE];
  assign adv_n = ctrl_s[POS_ADV];
  assign hr_n = ctrl_s[POS_HR];
  assign adv_rise = adv_n && !ctrl_prev_reg[POS_ADV];
  assign fclk_rise = ctrl_s[POS_FCLK] && !ctrl_prev_reg[POS_FCLK];
  // R1: select and reset gate reads
  assign rd_sel = hr_n && !ce_n && we_n;
  assign reading = rd_sel && !oe_n;
  assign wr_active = hr_n && !ce_n && !we_n && oe_n;
  // R7: first rise of either strobe ends the write
  assign wr_end = hr_n && oe_n && (ce_n || we_n)
                  && !ctrl_prev_reg[POS_CE] && !ctrl_prev_reg[POS_WE];

  // Block index from the upper address bits
  // R2: block decode
  function automatic logic [BLK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
    block_of = a[ADDR_W-1 -: BLK_W];
  endfunction

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] addr_lat_reg;
  logic captured_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic sync_mode_reg;
  flbc_rd_mode_t rd_mode_reg;
  flbc_cmd_state_t cmd_reg;
  flbc_wsm_state_t wsm_reg;
  logic [31:0] cnt_reg;
  logic [ADDR_W-1:0] tgt_reg;
  logic [7:0] status_w;
  logic busy;

  assign busy = (wsm_reg != WSM_IDLE);
  assign status_w = {!busy, 7'h00};

  // ----------------------------------------------------------------
  // Address latch
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_lat_reg <= '0;
      captured_reg <= 1'b0;
    end else if (!hr_n) begin
      captured_reg <= 1'b0;
    end else if (rd_sel) begin
      if (!sync_mode_reg) begin
        // R3: flow-through while low, last value held after rise
        if (!adv_n) begin
          addr_lat_reg <= addr_s;
        end
      end else if (!adv_n && !captured_reg && fclk_rise) begin
        // R4: clock edge with address valid low
        addr_lat_reg <= addr_s;
        captured_reg <= 1'b1;
      end else if (adv_rise && !captured_reg) begin
        // R4: address valid rise came first
        addr_lat_reg <= addr_s;
        captured_reg <= 1'b1;
      end else if (adv_n) begin
        captured_reg <= captured_reg && !adv_rise;
      end
      if (adv_n && captured_reg && !ctrl_prev_reg[POS_ADV]) begin
        captured_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write capture
  // ----------------------------------------------------------------
  // Holds the last sample seen while both strobes were low
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else if (wr_active) begin
      // R7: address and data follow the bus until the strobe rises
      wr_addr_reg <= addr_s;
      wr_data_reg <= data_s;
    end
  end

  // ----------------------------------------------------------------
  // Command interface and write state machine
  // ----------------------------------------------------------------
  logic wr_go;
  assign wr_go = wr_end && (!busy || wr_data_reg[7:0] == CMD_READ_STATUS);

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_mode_reg <= RD_ARRAY;
      cmd_reg <= CMD_ST_IDLE;
      sync_mode_reg <= 1'b0;
    end else if (!hr_n) begin
      // R11: back to asynchronous array read
      rd_mode_reg <= RD_ARRAY;
      cmd_reg <= CMD_ST_IDLE;
      sync_mode_reg <= 1'b0;
    end else if (wr_go) begin
      // R15: commands decoded from data, address names target or carries the sync mode bit
      case (cmd_reg)
        CMD_ST_PROG: begin
          cmd_reg <= CMD_ST_IDLE;
          rd_mode_reg <= RD_STATUS;
        end
        CMD_ST_ERASE: begin
          cmd_reg <= CMD_ST_IDLE;
          rd_mode_reg <= RD_STATUS;
        end
        CMD_ST_CONFIG: begin
          cmd_reg <= CMD_ST_IDLE;
          if (wr_data_reg[7:0] == CMD_CONFIG_SET) begin
            sync_mode_reg <= wr_addr_reg[SYNC_MODE_ADDR_BIT];
          end
        end
        default: begin
          case (wr_data_reg[7:0])
            // R20: back to array read
            CMD_READ_ARRAY: rd_mode_reg <= RD_ARRAY;
            CMD_READ_STATUS: rd_mode_reg <= RD_STATUS;
            CMD_CLEAR_STATUS: rd_mode_reg <= rd_mode_reg;
            CMD_PROGRAM: cmd_reg <= CMD_ST_PROG;
            CMD_PROGRAM_ALT: cmd_reg <= CMD_ST_PROG;
            CMD_ERASE: cmd_reg <= CMD_ST_ERASE;
            CMD_CONFIG: cmd_reg <= CMD_ST_CONFIG;
            default: cmd_reg <= CMD_ST_IDLE;
          endcase
        end
      endcase
    end
  end

  // Erase applies in one step; a cheap model of a block-wide erase
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wsm_reg <= WSM_IDLE;
      cnt_reg <= '0;
      tgt_reg <= '0;
      invalid_blocks_out <= '0;
    end else if (!hr_n) begin
      // R12: abort at once; R13: target becomes invalid
      // R19: abort finishes in one cycle
      if (busy) begin
        invalid_blocks_out[block_of(tgt_reg)] <= 1'b1;
      end
      wsm_reg <= WSM_IDLE;
      cnt_reg <= '0;
    end else begin
      case (wsm_reg)
        WSM_PROG, WSM_ERASE: begin
          // R16: autonomous count; R10: select level not consulted
          if (cnt_reg <= 32'h1) begin
            wsm_reg <= WSM_IDLE;
            if (wsm_reg == WSM_ERASE) begin
              for (int i = 0; i < DEPTH; i++) begin
                if (block_of(ADDR_W'(i)) == block_of(tgt_reg)) begin
                  mem[i] <= ERASED_WORD;
                end
              end
              invalid_blocks_out[block_of(tgt_reg)] <= 1'b0;
            end else begin
              mem[tgt_reg] <= mem[tgt_reg] & wr_data_reg;
            end
          end else begin
            cnt_reg <= cnt_reg - 32'h1;
          end
        end
        default: begin
          wsm_reg <= WSM_IDLE;
          if (wr_go && cmd_reg == CMD_ST_PROG) begin
            wsm_reg <= WSM_PROG;
            cnt_reg <= 32'(PROG_CYC);
            tgt_reg <= wr_addr_reg;
          end else if (wr_go && cmd_reg == CMD_ST_ERASE
                       && wr_data_reg[7:0] == CMD_CONFIRM) begin
            wsm_reg <= WSM_ERASE;
            cnt_reg <= 32'(ERASE_CYC);
            tgt_reg <= wr_addr_reg;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_out <= '0;
    end else if (rd_mode_reg == RD_ARRAY && !busy) begin
      dq_out <= mem[addr_lat_reg];
    end else begin
      dq_out <= {8'h00, status_w};
    end
  end

  // R8: R9: R12: drivers only while reading
  assign dq_oe_out = reading;
  // R21: sync reads drive wait; deasserted level is high
  assign wait_oe_out = reading && sync_mode_reg;
  assign wait_out = 1'b1;
  assign wsm_busy_out = busy;
  assign sync_mode_out = sync_mode_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_read_gate: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) dq_oe_out |-> (!ce_n && hr_n)) else $error("data driven without select"); // R1
  chk_async_latch: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) (!sync_mode_reg && rd_sel && !adv_n) |=> addr_lat_reg == $past(addr_s)) else $error("async latch not transparent"); // R3
  chk_sync_capture: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) (sync_mode_reg && rd_sel && !adv_n && !captured_reg && fclk_rise) |=> (addr_lat_reg == $past(addr_s)) && captured_reg) else $error("sync capture missed"); // R4
  chk_write_capture: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) wr_active ##1 !wr_active |-> wr_data_reg == $past(data_s, 2)) else $error("write data not held"); // R7
  chk_oe_float: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) oe_n |-> !dq_oe_out && !wait_oe_out) else $error("pins driven with output enable high"); // R8
  chk_standby_float: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) ce_n |-> !dq_oe_out) else $error("pins driven in standby"); // R9
  chk_deselect_runs: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) (ce_n && hr_n && busy && cnt_reg > 32'h1) |=> busy) else $error("deselect stopped operation"); // R10
  chk_reset_state: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) $rose(hr_n) |-> rd_mode_reg == RD_ARRAY && !sync_mode_reg && status_w == STATUS_RESET) else $error("wrong state after reset"); // R11
  chk_reset_abort: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) (!hr_n && busy) |=> !busy && invalid_blocks_out[block_of(tgt_reg)]) else $error("abort not done or not marked"); // R13
  chk_abort_bound: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) !hr_n |-> ##[1:2] !busy) else $error("reset took too long"); // R19
  chk_read_array: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) (wr_go && cmd_reg == CMD_ST_IDLE && wr_data_reg[7:0] == CMD_READ_ARRAY) |=> rd_mode_reg == RD_ARRAY) else $error("read array ignored"); // R20
  chk_wait_driven: assert property (@(posedge ref_clk_in) disable iff (!resetn_in) (reading && sync_mode_reg) |-> wait_oe_out && wait_out) else $error("wait not driven"); // R21

endmodule

// file: test/flbc_host.sv
// Host-side bus model driving the flash control pins
`timescale 1ns/10ps
module flbc_host (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  output logic hard_reset_n_out,
  output logic flash_clk_out,
  output logic chip_sel_n_out,
  output logic out_en_n_out,
  output logic write_en_n_out,
  output logic address_valid_n_out,
  output logic [7:0] addr_out,
  output logic [15:0] dq_out
);
  logic hr_reg = 1'b1;
  logic run_reg = 1'b0;
  logic [1:0] div_reg = 2'h0;

  initial begin
    chip_sel_n_out = 1'b1;
    out_en_n_out = 1'b1;
    write_en_n_out = 1'b1;
    address_valid_n_out = 1'b1;
    addr_out = 8'h00;
    dq_out = 16'h0000;
  end

  // Bus clock stands still between sync reads
  // Divided by four so the pin filter sees each level settle
  initial flash_clk_out = 1'b0;
  always @(posedge ref_clk_in) begin
    div_reg <= run_reg ? div_reg + 2'h1 : 2'h0;
    flash_clk_out <= run_reg ? div_reg[1] : 1'b0;
  end

  assign hard_reset_n_out = resetn_in & hr_reg;

  task automatic hr(input logic lvl);
    #1;
    hr_reg = lvl;
    repeat (lvl ? 12 : 1) @(posedge ref_clk_in);
  endtask

  // strobe and select low, rise together
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    #1;
    addr_out = a;
    dq_out = d;
    address_valid_n_out = 1'b0;
    chip_sel_n_out = 1'b0;
    write_en_n_out = 1'b0;
    repeat (6) @(posedge ref_clk_in);
    #1;
    write_en_n_out = 1'b1;
    chip_sel_n_out = 1'b1;
    address_valid_n_out = 1'b1;
    // Released bus must not look like held data
    dq_out = ~d;
    repeat (6) @(posedge ref_clk_in);
  endtask

  // write enable kept high while reading
  task automatic drive(input logic [7:0] a, input logic ce_n,
                       input logic oe_n, input logic sync);
    #1;
    addr_out = a;
    address_valid_n_out = 1'b0;
    chip_sel_n_out = ce_n;
    out_en_n_out = oe_n;
    run_reg = sync;
  endtask

  // close the latch, then move the address
  task automatic latch(input logic [7:0] a);
    #1;
    address_valid_n_out = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    addr_out = a;
    repeat (6) @(posedge ref_clk_in);
  endtask

  task automatic release_bus();
    #1;
    chip_sel_n_out = 1'b1;
    out_en_n_out = 1'b1;
    address_valid_n_out = 1'b1;
    run_reg = 1'b0;
    repeat (6) @(posedge ref_clk_in);
  endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the flash bus-operation control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("mismatch %s expected %h seen %h", n, e, g); \
  end \
end
module tb;
  import flbc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hr_n, fclk, ce_n, oe_n, we_n, adv_n;
  logic [7:0] addr;
  logic [15:0] dq_in, dq_out;
  logic dq_oe, wait_o, wait_oe, busy, sync_mode;
  logic [3:0] inval;
  int error_cnt = 0;
  int tests_run = 0;

  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  flbc_host host (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .hard_reset_n_out(hr_n), .flash_clk_out(fclk),
    .chip_sel_n_out(ce_n), .out_en_n_out(oe_n),
    .write_en_n_out(we_n), .address_valid_n_out(adv_n),
    .addr_out(addr), .dq_out(dq_in));

  // Short program and erase times keep the run brief
  flbc_bus_ctrl #(.PROG_CYC(20),
    .ERASE_CYC(40)) uut (.ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .flash_clk_in(fclk),
    .hard_reset_n_in(hr_n), .chip_sel_n_in(ce_n),
    .out_en_n_in(oe_n), .write_en_n_in(we_n),
    .address_valid_n_in(adv_n), .addr_in(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_out(dq_oe), .wait_out(wait_o),
    .wait_oe_out(wait_oe), .wsm_busy_out(busy),
    .sync_mode_out(sync_mode), .invalid_blocks_out(inval));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 200 && busy !== lvl; i++) @(posedge ref_clk_in);
    if (busy !== lvl) begin
      error_cnt++;
      $display("mismatch busy wait expected %h seen %h", lvl, busy);
      close_out();
    end
  endtask

  task automatic read_chk(input logic [7:0] a, input logic [15:0] e);
    host.drive(a, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge ref_clk_in);
    `CHK("read drive", 1'b1, dq_oe)
    `CHK("read word", e, dq_out)
    host.release_bus();
  endtask

  task automatic t_idle();
    `CHK("idle drive", 1'b0, dq_oe)
    `CHK("idle wait drive", 1'b0, wait_oe)
    `CHK("idle busy", 1'b0, busy)
    `CHK("idle sync", 1'b0, sync_mode)
    `CHK("idle invalid", 4'h0, inval)
    `CHK("idle wait level", 1'b1, wait_o)
  endtask

  task automatic t_erase_prog();
    host.wr(8'h40, 16'h0020);
    host.wr(8'h40, 16'h00D0);
    `CHK("erase busy", 1'b1, busy)
    wait_busy(1'b0);
    read_chk(8'h45, 16'h0080);
    host.wr(8'h00, 16'h00FF);
    read_chk(8'h45, 16'hFFFF);
    host.wr(8'h45, 16'h0040);
    host.wr(8'h45, 16'h1234);
    repeat (8) @(posedge ref_clk_in);
    `CHK("deselected busy", 1'b1, busy)
    wait_busy(1'b0);
    host.wr(8'h00, 16'h00FF);
    read_chk(8'h45, 16'h1234);
    read_chk(8'h46, 16'hFFFF);
  endtask

  task automatic t_latch();
    host.drive(8'h45, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge ref_clk_in);
    host.latch(8'h46);
    `CHK("latched word", 16'h1234, dq_out)
    host.release_bus();
  endtask

  task automatic t_outputs();
    host.drive(8'h45, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge ref_clk_in);
    `CHK("disable drive", 1'b0, dq_oe)
    `CHK("disable wait", 1'b0, wait_oe)
    host.release_bus();
    host.drive(8'h45, 1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge ref_clk_in);
    `CHK("standby drive", 1'b0, dq_oe)
    host.release_bus();
  endtask

  task automatic t_sync();
    host.wr(8'h01, 16'h0060);
    host.wr(8'h01, 16'h0003);
    `CHK("sync mode", 1'b1, sync_mode)
    host.drive(8'h46, 1'b0, 1'b0, 1'b1);
    repeat (10) @(posedge ref_clk_in);
    `CHK("sync word", 16'hFFFF, dq_out)
    `CHK("sync wait drive", 1'b1, wait_oe)
    `CHK("sync wait level", 1'b1, wait_o)
    host.drive(8'h45, 1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge ref_clk_in);
    `CHK("sync disable wait", 1'b0, wait_oe)
    host.release_bus();
  endtask

  task automatic t_abort();
    host.wr(8'h80, 16'h0020);
    host.wr(8'h80, 16'h00D0);
    `CHK("abort busy", 1'b1, busy)
    host.hr(1'b0);
    host.drive(8'h80, 1'b0, 1'b0, 1'b0);
    repeat (30) @(posedge ref_clk_in);
    `CHK("abort stops", 1'b0, busy)
    `CHK("abort invalid", 4'h4, inval)
    `CHK("reset drive", 1'b0, dq_oe)
    host.release_bus();
    host.hr(1'b1);
    `CHK("reset sync", 1'b0, sync_mode)
    host.wr(8'h00, 16'h0070);
    read_chk(8'h00, 16'h0080);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_in);
    #1;
    resetn_in = 1'b1;
    repeat (12) @(posedge ref_clk_in);
    t_idle();
    t_erase_prog();
    t_latch();
    t_outputs();
    t_sync();
    t_abort();
    close_out();
  end
endmodule
